// file: logic/burst_flash_host_bus.sv
// burst flash host bus protocol: burst and async reads, reset recovery, op timing
// Summary of operation
// - power saving on adds exactly one wait state before first burst word for latency counts 1 to 14
// - in linear bursts only, at a 64-word boundary insert two stall cycles, shown on ready low
// - initial latency follows the programmed total clock-cycle count
// - reset during program or erase aborts, read mode within 20 us
// - reset while idle also waits out the 20 us busy recovery count before read mode
// - standby is set while reset is held, whatever the hold time, and clears after release
// - word program lasts 11.5 us, accelerated 4 us
// - sector erase lasts 0.4 s, preprogramming excluded
// - reads of another bank proceed during a write with no extra latency
// - unlock cycles decode only address bits below A16
// - async reads latch the address on rising edge of address valid
// - burst captures strobe and address on a clock edge, words follow
// - data, power-saving and ready outputs drive only with output enable
// - boundaries every 64 words from 3Eh, and also at address zero
// - wrapped bursts wrap within the aligned word group
`timescale 1ns/1ns
`include "burst_flash_consts.svh"
module burst_flash_host_bus #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int BANK_W = 2,
    parameter int CYC_READY_BUSY = `CYC_READY_BUSY,
    parameter int CYC_STANDBY = `CYC_STANDBY,
    parameter int CYC_PROG = `CYC_PROG,
    parameter int CYC_PROG_ACC = `CYC_PROG_ACC,
    parameter int CYC_ERASE = `CYC_ERASE
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipEnable_n,
    input wire logic outputEnable_n,
    input wire logic address_valid_strobe_n,
    input wire logic syncMode,
    input wire logic powerSaveEnable,
    input wire logic [3:0] latencyCount,
    input wire logic [1:0] wrapMode,
    input wire logic accelerate,
    input wire logic unlockCycle,
    input wire logic startProgram,
    input wire logic startErase,
    input wire logic [BANK_W-1:0] opBank,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [DATA_W-1:0] arrayData,
    output logic [ADDR_W-1:0] arrayAddr,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic ready,
    output logic power_saving_wait,
    output logic busyBank,
    output logic [BANK_W-1:0] busyBankId,
    output logic readMode,
    output logic standby,
    output logic [ADDR_W-1:0] commandAddr
);
    localparam int CNT_W = 32;
    burst_flash_pkg::read_state_t rdState, next_rdState;
    burst_flash_pkg::op_state_t opState, next_opState;
    logic [ADDR_W-1:0] addr, next_addr, startAddr, next_startAddr;
    logic [3:0] waitCnt, next_waitCnt;
    logic [1:0] stallCnt, next_stallCnt;
    logic [DATA_W-1:0] next_dataOut;
    logic next_dataOe, next_ready, next_ps;
    logic [CNT_W-1:0] opCnt, next_opCnt, rstCnt, next_rstCnt;
    logic next_busyBank, next_readMode, next_standby;
    logic [BANK_W-1:0] next_busyBankId;
    logic [ADDR_W-1:0] next_commandAddr, next_arrayAddr;
    logic avdPrev, wasBusy, next_wasBusy;
    logic [ADDR_W-1:0] nextWord;
    logic atBoundary;

    // address step with wrap in 8/16/32 word groups
    always_comb begin
        nextWord = addr + ADDR_W'(1);
        unique case (wrapMode)
            2'h1: nextWord = {addr[ADDR_W-1:3], 3'(addr[2:0] + 3'h1)};
            2'h2: nextWord = {addr[ADDR_W-1:4], 4'(addr[3:0] + 4'h1)};
            2'h3: nextWord = {addr[ADDR_W-1:5], 5'(addr[4:0] + 5'h1)};
            default: nextWord = addr + ADDR_W'(1);
        endcase
        atBoundary = (addr[5:0] == `BOUNDARY_OFFSET) || (addr == '0);
    end

    // read path state
    always_comb begin
        next_rdState = rdState;
        next_addr = addr;
        next_startAddr = startAddr;
        next_waitCnt = waitCnt;
        next_stallCnt = stallCnt;
        next_arrayAddr = arrayAddr;
        unique case (rdState)
            burst_flash_pkg::IDLE: begin
                if (!chipEnable_n && !address_valid_strobe_n && syncMode) begin
                    next_addr = addrIn;
                    next_startAddr = addrIn;
                    next_waitCnt = latencyCount + (powerSaveEnable ? 4'h1 : 4'h0);
                    next_rdState = burst_flash_pkg::WAIT;
                end else if (!chipEnable_n && address_valid_strobe_n && !avdPrev && !syncMode) begin
                    next_addr = addrIn;
                    next_waitCnt = `ASYNC_WAIT;
                    next_rdState = burst_flash_pkg::ASYNC;
                end
            end
            burst_flash_pkg::WAIT: begin
                next_arrayAddr = addr;
                if (waitCnt <= 4'h1) begin
                    next_rdState = burst_flash_pkg::BURST;
                end else begin
                    next_waitCnt = waitCnt - 4'h1;
                end
            end
            burst_flash_pkg::BURST: begin
                next_arrayAddr = nextWord;
                next_addr = nextWord;
                if (atBoundary && wrapMode == 2'h0) begin
                    next_stallCnt = `BOUNDARY_STALL;
                    next_rdState = burst_flash_pkg::STALL;
                end
            end
            burst_flash_pkg::STALL: begin
                next_stallCnt = stallCnt - 2'h1;
                if (stallCnt == 2'h1) begin
                    next_rdState = burst_flash_pkg::BURST;
                end
            end
            burst_flash_pkg::ASYNC: begin
                next_arrayAddr = addr;
                if (waitCnt != 4'h0) begin
                    next_waitCnt = waitCnt - 4'h1;
                end
                if (!address_valid_strobe_n) begin
                    next_rdState = burst_flash_pkg::IDLE;
                end
            end
        endcase
        if (chipEnable_n || opState == burst_flash_pkg::RECOVER) begin
            next_rdState = burst_flash_pkg::IDLE;
        end
    end

    // read path outputs, driven only while the bus is enabled
    always_comb begin
        next_dataOut = dataOut;
        next_ps = 1'b0;
        next_ready = 1'b0;
        next_dataOe = !chipEnable_n && !outputEnable_n;
        unique case (rdState)
            burst_flash_pkg::IDLE: begin
                next_ready = 1'b0;
            end
            burst_flash_pkg::WAIT: begin
                next_ps = powerSaveEnable && (waitCnt == 4'h1);
            end
            burst_flash_pkg::BURST: begin
                next_dataOut = arrayData;
                next_ready = 1'b1;
            end
            burst_flash_pkg::STALL: begin
                next_ready = 1'b0;
            end
            burst_flash_pkg::ASYNC: begin
                if (waitCnt == 4'h0) begin
                    next_dataOut = arrayData;
                    next_ready = 1'b1;
                end
            end
        endcase
        if (!next_dataOe) begin
            next_ready = 1'b0;
            next_ps = 1'b0;
        end
    end

    // unlock cycles keep only the low address bits
    always_comb begin
        next_commandAddr = commandAddr;
        if (unlockCycle) begin
            next_commandAddr = {{(ADDR_W-`UNLOCK_LOW_BITS){1'b0}},
                addrIn[`UNLOCK_LOW_BITS-1:0]};
        end
    end

    // embedded operation timing, reads stay available in other banks
    always_comb begin
        next_opState = opState;
        next_opCnt = opCnt;
        next_busyBank = busyBank;
        next_busyBankId = busyBankId;
        next_wasBusy = wasBusy;
        unique case (opState)
            burst_flash_pkg::READY: begin
                if (startProgram || startErase) begin
                    next_opState = burst_flash_pkg::BUSY;
                    next_busyBank = 1'b1;
                    next_busyBankId = opBank;
                    next_opCnt = startErase ? CNT_W'(CYC_ERASE) :
                        (accelerate ? CNT_W'(CYC_PROG_ACC) : CNT_W'(CYC_PROG));
                end
            end
            burst_flash_pkg::BUSY: begin
                if (opCnt <= CNT_W'(1)) begin
                    next_opState = burst_flash_pkg::READY;
                    next_busyBank = 1'b0;
                end else begin
                    next_opCnt = opCnt - CNT_W'(1);
                end
            end
            burst_flash_pkg::RECOVER: begin
                if (opCnt <= CNT_W'(1)) begin
                    next_opState = burst_flash_pkg::READY;
                end else begin
                    next_opCnt = opCnt - CNT_W'(1);
                end
            end
        endcase
    end

    // recovery after reset release
    always_comb begin
        next_rstCnt = rstCnt;
        next_readMode = (opState == burst_flash_pkg::READY);
        next_standby = 1'b0;
        if (rstCnt != '0) begin
            next_rstCnt = rstCnt - CNT_W'(1);
            next_readMode = 1'b0;
        end
    end

    // read path registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdState <= burst_flash_pkg::IDLE;
            addr <= '0;
            startAddr <= '0;
            waitCnt <= `LATENCY_RESET;
            stallCnt <= '0;
            dataOut <= '0;
            dataOe <= 1'b0;
            ready <= 1'b0;
            power_saving_wait <= 1'b0;
            arrayAddr <= '0;
            avdPrev <= 1'b1;
        end else begin
            rdState <= next_rdState;
            addr <= next_addr;
            startAddr <= next_startAddr;
            waitCnt <= next_waitCnt;
            stallCnt <= next_stallCnt;
            dataOut <= next_dataOut;
            dataOe <= next_dataOe;
            ready <= next_ready;
            power_saving_wait <= next_ps;
            arrayAddr <= next_arrayAddr;
            avdPrev <= address_valid_strobe_n;
        end
    end

    // unlock address register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            commandAddr <= '0;
        end else begin
            commandAddr <= next_commandAddr;
        end
    end

    // embedded operation registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyBank <= 1'b0;
            busyBankId <= '0;
            opState <= burst_flash_pkg::RECOVER;
            opCnt <= CNT_W'(CYC_READY_BUSY);
            wasBusy <= 1'b0;
        end else begin
            busyBank <= next_busyBank;
            busyBankId <= next_busyBankId;
            opState <= next_opState;
            opCnt <= next_opCnt;
            wasBusy <= next_wasBusy;
        end
    end

    // recovery registers, idle bound never longer than the busy bound
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readMode <= 1'b0;
            standby <= 1'b1;
            rstCnt <= CNT_W'((CYC_READY_BUSY < `CYC_READY_IDLE) ?
                CYC_READY_BUSY : `CYC_READY_IDLE);
        end else begin
            readMode <= next_readMode;
            standby <= next_standby;
            rstCnt <= next_rstCnt;
        end
    end
endmodule

// file: logic/burst_flash_consts.svh
// constants for the burst flash host bus block
`ifndef BURST_FLASH_CONSTS_SVH
`define BURST_FLASH_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define T_READY_BUSY_US 20
`define T_READY_IDLE_NS 500
`define T_STANDBY_US 20
`define T_PROG_NS 11500
`define T_PROG_ACC_NS 4000
`define T_ERASE_MS 400
`define CYC_READY_BUSY ((`T_READY_BUSY_US * 1000) / `CLK_PERIOD_NS)
`define CYC_READY_IDLE (`T_READY_IDLE_NS / `CLK_PERIOD_NS)
`define CYC_STANDBY (((`T_STANDBY_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_PROG (`T_PROG_NS / `CLK_PERIOD_NS)
`define CYC_PROG_ACC (`T_PROG_ACC_NS / `CLK_PERIOD_NS)
`define CYC_ERASE ((`T_ERASE_MS * 1000000) / `CLK_PERIOD_NS)
`define BOUNDARY_MASK 6'h3f
`define BOUNDARY_OFFSET 6'h3e
`define BOUNDARY_STALL 2'h2
`define UNLOCK_LOW_BITS 16
`define LATENCY_RESET 4'h4
`define ASYNC_WAIT 4'h1
`endif

// file: logic/burst_flash_pkg.sv
// types for the burst flash host bus block
package burst_flash_pkg;
    typedef enum logic [4:0] {
        IDLE = 5'b0_0001,
        WAIT = 5'b0_0010,
        BURST = 5'b0_0100,
        STALL = 5'b0_1000,
        ASYNC = 5'b1_0000
    } read_state_t;
    typedef enum logic [2:0] {
        READY = 3'b001,
        BUSY = 3'b010,
        RECOVER = 3'b100
    } op_state_t;
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
        logic write;
    } bus_req_t;
endpackage

// file: verification/flash_array_model.sv
// array model answering each word address with a fixed pattern
`timescale 1ns/1ns
module flash_array_model (
    input wire logic [21:0] arrayAddr,
    output logic [15:0] arrayData
);
    assign arrayData = arrayAddr[15:0] ^ 16'h5a5a;
endmodule

// file: verification/burst_flash_host_bus_asserts.sv
// port checker for the burst flash host bus
`timescale 1ns/1ns
module burst_flash_host_bus_asserts #(
    parameter int CYC_READY_BUSY = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipEnable_n,
    input wire logic outputEnable_n,
    input wire logic address_valid_strobe_n,
    input wire logic syncMode,
    input wire logic powerSaveEnable,
    input wire logic [3:0] latencyCount,
    input wire logic unlockCycle,
    input wire logic startProgram,
    input wire logic [1:0] opBank,
    input wire logic [21:0] addrIn,
    input wire logic dataOe,
    input wire logic ready,
    input wire logic power_saving_wait,
    input wire logic busyBank,
    input wire logic [1:0] busyBankId,
    input wire logic readMode,
    input wire logic [21:0] commandAddr
);
    localparam int REC_MAX = CYC_READY_BUSY + 4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence take_s;
        $fell(address_valid_strobe_n) && syncMode && !chipEnable_n && !outputEnable_n
            && latencyCount == 4'h4;
    endsequence
    sequence async_take_s;
        $rose(address_valid_strobe_n) && !syncMode && !chipEnable_n && !outputEnable_n;
    endsequence
    oe_release_a: assert property (
        outputEnable_n[*2] |-> !ready && !dataOe && !power_saving_wait)
        else $error("outputs driven without enable");
    ready_drive_a: assert property (ready |-> dataOe)
        else $error("ready without bus drive");
    burst_latency_a: assert property (
        take_s and !powerSaveEnable |=> !ready[*5] ##1 ready)
        else $error("burst latency wrong");
    ps_latency_a: assert property (
        take_s and powerSaveEnable |=> !ready[*6] ##1 ready)
        else $error("power save latency wrong");
    ps_wait_a: assert property (power_saving_wait |-> !ready ##1 ready)
        else $error("extra wait not last");
    async_latency_a: assert property (async_take_s |-> ##2 !ready ##1 ready)
        else $error("async latency wrong");
    unlock_addr_a: assert property (
        unlockCycle |=> commandAddr == {6'h00, $past(addrIn[15:0])})
        else $error("unlock address wrong");
    op_start_a: assert property (
        startProgram && !busyBank |=> busyBank && busyBankId == $past(opBank))
        else $error("busy bank wrong");
    reset_recover_a: assert property ($rose(rst_n) |-> ##[1:REC_MAX] readMode)
        else $error("read mode late");
endmodule
bind burst_flash_host_bus burst_flash_host_bus_asserts #(
    .CYC_READY_BUSY(CYC_READY_BUSY)) i_chk (.*);

// file: verification/burst_flash_host_bus_tb.sv
// self-checking bench for the burst flash host bus
`timescale 1ns/1ns
module burst_flash_host_bus_tb;
    localparam int PROG = 40;
    localparam int ACC = 16;
    localparam int ERS = 60;
    logic clk = 0, rst_n, chipEnable_n = 1, outputEnable_n = 1, lastPs;
    logic address_valid_strobe_n = 1, syncMode = 0, powerSaveEnable = 0, accelerate = 0;
    logic unlockCycle = 0, startProgram = 0, startErase = 0;
    logic [3:0] latencyCount = 4'h4;
    logic [1:0] wrapMode = 2'h0, opBank = 2'h0, busyBankId;
    logic [21:0] addrIn = 22'h00_0000, arrayAddr, commandAddr;
    logic [15:0] arrayData, dataOut;
    logic dataOe, ready, power_saving_wait, busyBank, readMode, standby;
    int errTotal = 0, nTests = 0, busyCnt = 0;
    burst_flash_host_bus #(.CYC_READY_BUSY(8), .CYC_STANDBY(10), .CYC_PROG(PROG),
        .CYC_PROG_ACC(ACC), .CYC_ERASE(ERS)) i_dut (.*);
    flash_array_model i_mem (.arrayAddr(arrayAddr), .arrayData(arrayData));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (busyBank === 1'b1) begin
            busyCnt++;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic waitReady(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (ready !== 1'b1) lastPs = power_saving_wait;
        end while (ready !== 1'b1 && n < 60);
        if (n >= 60) begin
            errTotal++;
            giveVerdict();
        end
    endtask
    task automatic startRead(input logic [21:0] a, input logic s, p, input logic [1:0] w);
        @(posedge clk);
        syncMode <= s;
        powerSaveEnable <= p;
        wrapMode <= w;
        chipEnable_n <= 0;
        outputEnable_n <= 0;
        address_valid_strobe_n <= 0;
        addrIn <= a;
        @(posedge clk);
        address_valid_strobe_n <= 1;
    endtask
    task automatic endRead();
        @(posedge clk);
        outputEnable_n <= 1;
        repeat (2) @(negedge clk);
        chk({dataOe, ready, power_saving_wait}, 3'b000);
        @(posedge clk);
        chipEnable_n <= 1;
        @(posedge clk);
    endtask
    task automatic tBurst(input logic [21:0] a0, input logic p, input logic [1:0] w,
        input int stall);
        int n;
        logic [21:0] a;
        logic [21:0] m;
        a = a0;
        m = (22'h00_0004 << w) - 22'h00_0001;
        startRead(a0, 1'b1, p, w);
        waitReady(n);
        chk(n, 6 + p);
        chk(lastPs, p);
        for (int i = 0; i < 7; i++) begin
            chk(ready, i != stall && i != stall + 1);
            if (ready === 1'b1) begin
                chk(dataOut, a[15:0] ^ 16'h5a5a);
                a = (w == 2'h0) ? a + 1 : (a & ~m) | ((a + 1) & m);
            end
            @(negedge clk);
        end
        endRead();
    endtask
    task automatic tAsync();
        int n;
        for (int k = 0; k < 2; k++) begin
            startRead(22'h00_0100, 1'b0, 1'b0, 2'h0);
            waitReady(n);
            chk(n, 4);
            chk(dataOut, 16'h5b5a);
            endRead();
        end
    endtask
    task automatic tUnlock();
        @(posedge clk);
        unlockCycle <= 1;
        addrIn <= 22'h3f_1234;
        @(posedge clk);
        unlockCycle <= 0;
        @(negedge clk);
        chk(commandAddr, 22'h00_1234);
    endtask
    task automatic tOp(input logic er, input logic acc, input int exp);
        int n;
        busyCnt = 0;
        @(posedge clk);
        accelerate <= acc;
        opBank <= 2'h2;
        startProgram <= !er;
        startErase <= er;
        @(posedge clk);
        startProgram <= 0;
        startErase <= 0;
        @(negedge clk);
        chk({busyBank, busyBankId}, 3'b110);
        startRead(22'h00_0020, 1'b1, 1'b0, 2'h0);
        waitReady(n);
        chk(n, 6);
        endRead();
        for (int i = 0; i < 100 && busyBank === 1'b1; i++) begin
            @(negedge clk);
        end
        if (busyBank === 1'b1) begin
            errTotal++;
            giveVerdict();
        end
        chk(busyCnt, exp);
    endtask
    task automatic tReset(input int hold, input logic busy);
        int n;
        @(posedge clk);
        startProgram <= busy;
        @(posedge clk);
        startProgram <= 0;
        rst_n <= 0;
        repeat (hold) @(negedge clk);
        chk({standby, readMode, busyBank}, 3'b100);
        @(posedge clk);
        rst_n <= 1;
        n = 0;
        while (readMode !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) begin
            errTotal++;
            giveVerdict();
        end
        chk(n <= 12, 1'b1);
        repeat (20) @(posedge clk);
    endtask
    initial begin
        rst_n <= 1'b0;
        tReset(2, 1'b0);
        tBurst(22'h00_0010, 1'b0, 2'h0, 9);
        tBurst(22'h00_0010, 1'b1, 2'h0, 9);
        tBurst(22'h00_003B, 1'b0, 2'h0, 4);
        tBurst(22'h00_0000, 1'b0, 2'h0, 1);
        for (int w = 1; w < 4; w++) begin
            tBurst((22'h00_0004 << w) - 22'h00_0002, 1'b0, w[1:0], 9);
        end
        tAsync();
        tUnlock();
        tOp(1'b0, 1'b0, PROG);
        tOp(1'b0, 1'b1, ACC);
        tOp(1'b0, 1'b1, ACC);
        tOp(1'b1, 1'b0, ERS);
        tReset(12, 1'b1);
        giveVerdict();
    end
endmodule
